// [logic/pcr_pkg.sv]
// Behaviour
// - Button hold time before reset is 8 s when bit clear, 15 s when set.
// - Output pin 2 is open-drain at 0, push-pull from switch-1 supply at 1.
// - Mode select clear: pin 1 is open-drain output, pin 2 driven independently.
// - Mode select set: pin 1 is input whose level drives output pin 2.
// - Power-good delay field bits 4-3 picks 10/20/50/150 ms, reset code 1.
// - Delay only on power-good rise; fall or fault deasserts at once.
// - Tight bit clear: wide falling limits, overvoltage not monitored.
// - Tight bit set, reset state: tight limits and overvoltage flagged.
// - Warm-reset enable clear: pin 3 is output set by its level bit.
// - Warm-reset enable set, reset state: pin 3 is warm-reset input to bucks.
// - Switch 3 limit field bits 3-2 picks 100/200/500/1000 mA, resets to 0.
// - Switch 2 limit field bits 1-0 picks 100/200/500/1000 mA, resets to 0.
// - Warm-reset enable set makes the pin-3 level bit ineffective.
// - Mode select set makes the pin-1 and pin-2 level bits ineffective.
package pcr_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CFG_ONE = 8'h13;
    localparam logic [7:0] IDX_CFG_TWO = 8'h14;
    localparam logic [7:0] IDX_PIN_LEVEL = 8'h18;
    localparam logic [7:0] IDX_STATUS = 8'h19;

    // Reset values
    localparam logic [7:0] RST_CFG_ONE = 8'h4C;
    localparam logic [7:0] RST_CFG_TWO = 8'hC0;
    localparam logic [2:0] RST_PIN_LEVEL = 3'h0;

    // Field positions
    localparam int POS_PGOOD_DELAY = 3;
    localparam int POS_SW3_LIMIT = 2;
    localparam int POS_SW2_LIMIT = 0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Timing
    localparam longint unsigned CLK_HZ = 250_000_000;
    localparam longint unsigned CLK_PER_MS = CLK_HZ / 1000;
    localparam longint unsigned PB_HOLD_SHORT_S = 8;
    localparam longint unsigned PB_HOLD_LONG_S = 15;
    localparam longint unsigned PB_SHORT_CYC = PB_HOLD_SHORT_S * CLK_HZ;
    localparam longint unsigned PB_LONG_CYC = PB_HOLD_LONG_S * CLK_HZ;
    localparam longint unsigned PG_DLY0_MS = 10;
    localparam longint unsigned PG_DLY1_MS = 20;
    localparam longint unsigned PG_DLY2_MS = 50;
    localparam longint unsigned PG_DLY3_MS = 150;
    localparam longint unsigned PG_DLY0_CYC = PG_DLY0_MS * CLK_PER_MS;
    localparam longint unsigned PG_DLY1_CYC = PG_DLY1_MS * CLK_PER_MS;
    localparam longint unsigned PG_DLY2_CYC = PG_DLY2_MS * CLK_PER_MS;
    localparam longint unsigned PG_DLY3_CYC = PG_DLY3_MS * CLK_PER_MS;

    // Current limit encodings, in mA
    typedef enum logic [1:0] {
        LIM_100MA = 2'h0,
        LIM_200MA = 2'h1,
        LIM_500MA = 2'h2,
        LIM_1000MA = 2'h3
    } pcr_limit_type;

    // First configuration register layout
    typedef struct packed {
        logic hold_long;
        logic out2_buffer_type;
        logic pin1_mode_select;
        logic [1:0] pgood_delay_sel;
        logic supervisor_tight_mode;
        logic [1:0] undervoltage_lockout_level;
    } pcr_cfg_one_type;

    // Second configuration register layout
    typedef struct packed {
        logic core_warm_reset_enable;
        logic lockout_hysteresis_sel;
        logic [1:0] reserved;
        pcr_limit_type switch3_current_limit;
        pcr_limit_type switch2_current_limit;
    } pcr_cfg_two_type;

    // Analog trim outputs bundled for the converters and switches
    typedef struct packed {
        logic [1:0] undervoltage_lockout_level;
        logic lockout_hysteresis_sel;
        logic supervisor_tight_mode;
        pcr_limit_type switch3_current_limit;
        pcr_limit_type switch2_current_limit;
    } pcr_trim_type;

endpackage : pcr_pkg

// [logic/pcr_config_regs.sv]
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module pcr_config_regs #(
    parameter int ADDR_W = 8,
    parameter logic [31:0] PB_SHORT_CYCLES = 32'(pcr_pkg::PB_SHORT_CYC),
    parameter logic [31:0] PB_LONG_CYCLES = 32'(pcr_pkg::PB_LONG_CYC),
    parameter logic [31:0] PG_DLY0_CYCLES = 32'(pcr_pkg::PG_DLY0_CYC),
    parameter logic [31:0] PG_DLY1_CYCLES = 32'(pcr_pkg::PG_DLY1_CYC),
    parameter logic [31:0] PG_DLY2_CYCLES = 32'(pcr_pkg::PG_DLY2_CYC),
    parameter logic [31:0] PG_DLY3_CYCLES = 32'(pcr_pkg::PG_DLY3_CYC)
) (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    // AXI4-Lite write channels
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read channels
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Analog-side inputs, asynchronous
    input wire logic button_b,
    input wire logic pgood_raw,
    input wire logic overvoltage_raw,
    // Pin 1
    input wire logic pin1_io_in,
    output logic pin1_io_out,
    output logic pin1_io_oe_b,
    // Output pin 2
    output logic output2_pin_out,
    output logic output2_pin_oe_b,
    // Pin 3
    input wire logic pin3_io_in,
    output logic pin3_io_out,
    output logic pin3_io_oe_b,
    // Block outputs
    output logic pb_reset,
    output logic pgood,
    output logic overvoltage_flag,
    output logic buck_warm_reset,
    output pcr_pkg::pcr_trim_type trim
);
    import pcr_pkg::*;

    localparam logic [ADDR_W-1:0] ADDR_ONE = ADDR_W'({IDX_CFG_ONE, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_TWO = ADDR_W'({IDX_CFG_TWO, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_LVL = ADDR_W'({IDX_PIN_LEVEL, 2'b00});
    localparam logic [ADDR_W-1:0] ADDR_STS = ADDR_W'({IDX_STATUS, 2'b00});

    // Refuse settings the decoder or counters cannot serve
    if (ADDR_W < 10 - 2 || ADDR_W > 32) begin : g_bad_addr
        $error("ADDR_W must lie between 8 and 32");
    end
    if (PB_SHORT_CYCLES == 0 || PB_LONG_CYCLES == 0 || PG_DLY0_CYCLES == 0 ||
        PG_DLY1_CYCLES == 0 || PG_DLY2_CYCLES == 0 || PG_DLY3_CYCLES == 0) begin : g_bad_cnt
        $error("Timing counts must be at least one cycle");
    end

    pcr_cfg_one_type cfg_one_q;
    pcr_cfg_two_type cfg_two_q;
    logic [2:0] level_q;
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic button_s, pgood_s, ov_s, pin1_s, pin3_s;
    logic pin1_s1_q, pin1_s2_q, pin3_s1_q, pin3_s2_q;
    logic aw_got_q, w_got_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [7:0] wbyte_q;
    logic wlane_q;
    logic wr_go, aw_hs, w_hs, ar_hs;
    logic [31:0] pb_cnt_q, pb_target;
    logic [31:0] pg_cnt_q, pg_target;
    logic [31:0] rd_mux;
    logic rd_hit;
    logic pin2_level;

    // Two-flop synchronisers; the first stage feeds only the second
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            sync1_q <= 4'hF;
            sync2_q <= 4'hF;
            pin1_s1_q <= 1'b1;
            pin1_s2_q <= 1'b1;
            pin3_s1_q <= 1'b1;
            pin3_s2_q <= 1'b1;
        end else if (ce) begin
            sync1_q <= {button_b, pgood_raw, overvoltage_raw, 1'b0};
            sync2_q <= sync1_q;
            pin1_s1_q <= pin1_io_in;
            pin1_s2_q <= pin1_s1_q;
            pin3_s1_q <= pin3_io_in;
            pin3_s2_q <= pin3_s1_q;
        end
    end
    assign button_s = sync2_q[3];
    assign pgood_s = sync2_q[2];
    assign ov_s = sync2_q[1];
    assign pin1_s = pin1_s2_q;
    assign pin3_s = pin3_s2_q;

    // Write channels; address and data latch independently
    assign awready = ce & ~aw_got_q & ~bvalid;
    assign wready = ce & ~w_got_q & ~bvalid;
    assign aw_hs = awvalid & awready;
    assign w_hs = wvalid & wready;
    assign wr_go = ce & aw_got_q & w_got_q & ~bvalid;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= '0;
            wbyte_q <= 8'h00;
            wlane_q <= 1'b0;
        end else if (ce) begin
            if (aw_hs) begin
                aw_got_q <= 1'b1;
                awaddr_q <= awaddr;
            end else if (wr_go) begin
                aw_got_q <= 1'b0;
            end
            if (w_hs) begin
                w_got_q <= 1'b1;
                wbyte_q <= wdata[7:0];
                wlane_q <= wstrb[0];
            end else if (wr_go) begin
                w_got_q <= 1'b0;
            end
        end
    end

    // Write response; unmapped addresses answer SLVERR
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (ce) begin
            if (wr_go) begin
                bvalid <= 1'b1;
                bresp <= (awaddr_q == ADDR_ONE || awaddr_q == ADDR_TWO ||
                          awaddr_q == ADDR_LVL || awaddr_q == ADDR_STS) ?
                         RESP_OKAY : RESP_SLVERR;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Register storage; only byte lane 0 carries data
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cfg_one_q <= RST_CFG_ONE;
            cfg_two_q <= RST_CFG_TWO;
            level_q <= RST_PIN_LEVEL;
        end else if (wr_go && wlane_q) begin
            if (awaddr_q == ADDR_ONE) begin
                cfg_one_q <= wbyte_q;
            end
            if (awaddr_q == ADDR_TWO) begin
                cfg_two_q <= {wbyte_q[7:4] & 4'hC, wbyte_q[3:0]};
            end
            if (awaddr_q == ADDR_LVL) begin
                level_q <= wbyte_q[2:0];
            end
        end
    end

    // Read path; status is live block state
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        case (araddr)
            ADDR_ONE: rd_mux = {24'h00_0000, cfg_one_q};
            ADDR_TWO: rd_mux = {24'h00_0000, cfg_two_q};
            ADDR_LVL: rd_mux = {29'h0000_0000, level_q};
            ADDR_STS: rd_mux = {27'h000_0000, ~button_s, pin3_s, pin1_s,
                                overvoltage_flag, pgood};
            default: rd_hit = 1'b0;
        endcase
    end

    assign arready = ce & ~rvalid;
    assign ar_hs = arvalid & arready;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else if (ce) begin
            if (ar_hs) begin
                rvalid <= 1'b1;
                rdata <= rd_mux;
                rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // Push-button hold timer; one pulse per press
    assign pb_target = cfg_one_q.hold_long ? PB_LONG_CYCLES : PB_SHORT_CYCLES;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pb_cnt_q <= 32'h0000_0000;
            pb_reset <= 1'b0;
        end else if (ce) begin
            pb_reset <= 1'b0;
            if (button_s) begin
                pb_cnt_q <= 32'h0000_0000;
            end else if (pb_cnt_q < pb_target) begin
                pb_cnt_q <= pb_cnt_q + 32'h0000_0001;
                pb_reset <= (pb_cnt_q == pb_target - 32'h0000_0001);
            end
        end
    end

    // Power-good: delayed rise, immediate fall
    always_comb begin
        case (cfg_one_q.pgood_delay_sel)
            2'h0: pg_target = PG_DLY0_CYCLES;
            2'h1: pg_target = PG_DLY1_CYCLES;
            2'h2: pg_target = PG_DLY2_CYCLES;
            default: pg_target = PG_DLY3_CYCLES;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pg_cnt_q <= 32'h0000_0000;
            pgood <= 1'b0;
        end else if (ce) begin
            if (!pgood_s) begin
                pg_cnt_q <= 32'h0000_0000;
                pgood <= 1'b0;
            end else if (!pgood) begin
                if (pg_cnt_q >= pg_target - 32'h0000_0001) begin
                    pgood <= 1'b1;
                end else begin
                    pg_cnt_q <= pg_cnt_q + 32'h0000_0001;
                end
            end
        end
    end

    // Overvoltage only reported in tight mode
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            overvoltage_flag <= 1'b0;
            buck_warm_reset <= 1'b0;
        end else if (ce) begin
            overvoltage_flag <= cfg_one_q.supervisor_tight_mode & ~ov_s;
            buck_warm_reset <= cfg_two_q.core_warm_reset_enable & ~pin3_s;
        end
    end

    // Trim outputs straight from register fields
    assign trim.undervoltage_lockout_level = cfg_one_q.undervoltage_lockout_level;
    assign trim.lockout_hysteresis_sel = cfg_two_q.lockout_hysteresis_sel;
    assign trim.supervisor_tight_mode = cfg_one_q.supervisor_tight_mode;
    assign trim.switch3_current_limit = cfg_two_q.switch3_current_limit;
    assign trim.switch2_current_limit = cfg_two_q.switch2_current_limit;

    // Pin 1: open-drain output or released as input
    assign pin1_io_out = 1'b0;
    assign pin1_io_oe_b = cfg_one_q.pin1_mode_select | level_q[0];

    // Pin 2 level follows pin 1 in gating mode, so level bits are ignored there
    assign pin2_level = cfg_one_q.pin1_mode_select ? pin1_s : level_q[1];
    assign output2_pin_out = cfg_one_q.out2_buffer_type & pin2_level;
    assign output2_pin_oe_b = ~cfg_one_q.out2_buffer_type & pin2_level;

    // Pin 3: released as warm-reset input, else open-drain output
    assign pin3_io_out = 1'b0;
    assign pin3_io_oe_b = cfg_two_q.core_warm_reset_enable | level_q[2];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    reset_values_a: assert property (disable iff (1'b0) !rst_b |=>
        cfg_one_q == RST_CFG_ONE && cfg_two_q == RST_CFG_TWO)
        else $error("Configuration reset values wrong");
    reserved_zero_a: assert property (ar_hs && araddr == ADDR_TWO |=>
        rdata[5:4] == 2'b00 && rdata[7:6] == $past(cfg_two_q[7:6]))
        else $error("Reserved bits not zero");
    limit_write_a: assert property (wr_go && wlane_q && awaddr_q == ADDR_TWO |=>
        trim.switch3_current_limit == $past(wbyte_q[3:2]) &&
        trim.switch2_current_limit == $past(wbyte_q[1:0]))
        else $error("Current limit write lost");
    pgood_fall_a: assert property (ce && !pgood_s |=> !pgood)
        else $error("Power-good fall delayed");
    pgood_delay_a: assert property ($rose(pgood) |->
        $past(pg_cnt_q) == $past(pg_target) - 32'h0000_0001)
        else $error("Power-good rose at wrong count");
    pb_hold_a: assert property (pb_reset |->
        $past(pb_cnt_q) == $past(pb_target) - 32'h0000_0001 && !$past(button_s))
        else $error("Button reset at wrong hold time");
    ov_tight_a: assert property (overvoltage_flag |-> $past(cfg_one_q.supervisor_tight_mode))
        else $error("Overvoltage flagged in wide mode");
    pin3_input_a: assert property (cfg_two_q.core_warm_reset_enable |-> pin3_io_oe_b)
        else $error("Pin 3 driven in warm-reset mode");
    warm_reset_a: assert property (ce && cfg_two_q.core_warm_reset_enable && !pin3_s |=>
        buck_warm_reset)
        else $error("Warm reset not passed to bucks");
    pin2_gate_a: assert property (cfg_one_q.pin1_mode_select && cfg_one_q.out2_buffer_type |->
        pin1_io_oe_b && output2_pin_out == pin1_s2_q && !output2_pin_oe_b)
        else $error("Pin 2 not following pin 1");
    pin2_drain_a: assert property (!cfg_one_q.out2_buffer_type |-> !output2_pin_out)
        else $error("Open-drain pin 2 driven high");

endmodule : pcr_config_regs
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
    import pcr_pkg::*;

    // Byte addresses, shortened counts
    localparam logic [7:0] A_ONE = 8'(IDX_CFG_ONE * 4);
    localparam logic [7:0] A_TWO = 8'(IDX_CFG_TWO * 4);
    localparam logic [7:0] A_LVL = 8'(IDX_PIN_LEVEL * 4);
    localparam logic [7:0] A_STS = 8'(IDX_STATUS * 4);
    localparam int PB_S = 20;
    localparam int PB_L = 40;
    localparam int PG0 = 10;
    localparam int PG1 = 20;
    localparam int PG2 = 30;
    localparam int PG3 = 40;

    logic mclk = 1'b0, rst_b = 1'b0, ce = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic [3:0] lanes = 4'hF;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, d;
    logic button_b = 1'b1, pgood_raw = 1'b0, ov_raw_b = 1'b1, ext1 = 1'b1, ext3 = 1'b1;
    logic pin1_io_in, pin1_io_out, pin1_io_oe_b, pin3_io_in, pin3_io_out, pin3_io_oe_b;
    logic output2_pin_out, output2_pin_oe_b, pb_reset, pgood, overvoltage_flag, buck_warm_reset;
    pcr_trim_type trim;
    int err_total = 0, compares = 0, n;
    int pg_cyc [4] = '{PG0, PG1, PG2, PG3};

    // Open-drain wires with pull-up: low if either side pulls low
    assign pin1_io_in = ext1 & (pin1_io_oe_b | pin1_io_out);
    assign pin3_io_in = ext3 & (pin3_io_oe_b | pin3_io_out);

    initial begin
        forever #2 mclk = ~mclk;
    end

    // Shortened timers so every delay code fits in a short run
    pcr_config_regs #(.PB_SHORT_CYCLES(32'(PB_S)), .PB_LONG_CYCLES(32'(PB_L)),
        .PG_DLY0_CYCLES(32'(PG0)), .PG_DLY1_CYCLES(32'(PG1)), .PG_DLY2_CYCLES(32'(PG2)),
        .PG_DLY3_CYCLES(32'(PG3))) u_pcr_config_regs (
        .mclk(mclk), .rst_b(rst_b), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .button_b(button_b), .pgood_raw(pgood_raw), .overvoltage_raw(ov_raw_b),
        .pin1_io_in(pin1_io_in), .pin1_io_out(pin1_io_out), .pin1_io_oe_b(pin1_io_oe_b),
        .output2_pin_out(output2_pin_out), .output2_pin_oe_b(output2_pin_oe_b),
        .pin3_io_in(pin3_io_in), .pin3_io_out(pin3_io_out), .pin3_io_oe_b(pin3_io_oe_b),
        .pb_reset(pb_reset), .pgood(pgood), .overvoltage_flag(overvoltage_flag),
        .buck_warm_reset(buck_warm_reset), .trim(trim));

    task automatic results;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // Handshakes judged at the falling edge; inputs then hold until the next rise
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        logic aw_ok, w_ok, done;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        done = 1'b0;
        @(posedge mclk);
        awaddr <= a;
        wdata <= v;
        wstrb <= lanes;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(negedge mclk);
            if (awvalid === 1'b1 && awready === 1'b1) aw_ok = 1'b1;
            if (wvalid === 1'b1 && wready === 1'b1) w_ok = 1'b1;
            if (bvalid === 1'b1) begin
                r = bresp;
                done = 1'b1;
            end
            @(posedge mclk);
            if (aw_ok) awvalid <= 1'b0;
            if (w_ok) wvalid <= 1'b0;
            if (done) bready <= 1'b0;
        end
        if (!done) begin
            err_total++;
            results();
        end
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        logic a_ok, done;
        a_ok = 1'b0;
        done = 1'b0;
        @(posedge mclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(negedge mclk);
            if (arvalid === 1'b1 && arready === 1'b1) a_ok = 1'b1;
            if (rvalid === 1'b1) begin
                v = rdata;
                r = rresp;
                done = 1'b1;
            end
            @(posedge mclk);
            if (a_ok) arvalid <= 1'b0;
            if (done) rready <= 1'b0;
        end
        if (!done) begin
            err_total++;
            results();
        end
    endtask : rd

    // Counts falling edges until an output reaches a level; bounded
    task automatic wait_for(input int which, input logic lvl, output int cnt);
        logic hit;
        hit = 1'b0;
        for (cnt = 0; cnt < 200 && !hit; cnt++) begin
            @(negedge mclk);
            hit = (which == 0) ? (pgood === lvl) : (pb_reset === lvl);
        end
        if (!hit) begin
            err_total++;
            results();
        end
    endtask : wait_for

    // Lets synchronisers and register writes land before looking
    task automatic settle;
        repeat (5) @(negedge mclk);
    endtask : settle

    initial begin
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        rd(A_ONE, d, resp);
        chk("cfg one reset", d, 32'h4C);
        chk("cfg one resp", 32'(resp), 32'(RESP_OKAY));
        rd(A_TWO, d, resp);
        chk("cfg two reset", d, 32'hC0);
        chk("trim reset", 32'(trim), 32'h30);
        // Every limit code, the two fields set differently
        for (int c = 0; c < 4; c++) begin
            wr(A_TWO, {24'h0, 4'hC, 2'(c), ~2'(c)}, resp);
            rd(A_TWO, d, resp);
            chk("cfg two limits", d, {24'h0, 4'hC, 2'(c), ~2'(c)});
            chk("trim limits", 32'(trim[3:0]), 32'({2'(c), ~2'(c)}));
        end
        wr(A_TWO, 32'hFFFF_FFFF, resp);
        rd(A_TWO, d, resp);
        chk("cfg two reserved", d, 32'hCF);
        // Byte lane 0 off: write answered but nothing stored
        lanes = 4'hE;
        wr(A_TWO, 32'h0000_0033, resp);
        lanes = 4'hF;
        chk("lane off resp", 32'(resp), 32'(RESP_OKAY));
        rd(A_TWO, d, resp);
        chk("lane off ignored", d, 32'hCF);
        wr(A_TWO, 32'hC0, resp);
        wr(8'h80, 32'h55, resp);
        chk("unmapped write resp", 32'(resp), 32'(RESP_SLVERR));
        rd(8'h80, d, resp);
        chk("unmapped read resp", 32'(resp), 32'(RESP_SLVERR));
        chk("unmapped read data", d, 32'h0);
        // Output pins, open-drain and push-pull
        settle();
        chk("pin1 drives low", 32'(pin1_io_oe_b), 32'h0);
        chk("pin2 pushpull low", 32'({output2_pin_oe_b, output2_pin_out}), 32'h0);
        wr(A_LVL, 32'h3, resp);
        settle();
        chk("pin1 released", 32'(pin1_io_oe_b), 32'h1);
        chk("pin2 pushpull high", 32'({output2_pin_oe_b, output2_pin_out}), 32'h1);
        wr(A_ONE, 32'h0C, resp);
        settle();
        chk("pin2 open drain off", 32'(output2_pin_oe_b), 32'h1);
        wr(A_LVL, 32'h1, resp);
        settle();
        chk("pin2 open drain low", 32'({output2_pin_oe_b, output2_pin_out}), 32'h0);
        chk("pin1 independent", 32'(pin1_io_oe_b), 32'h1);
        // Pin 1 as input steering pin 2; level bits zero must not matter
        wr(A_LVL, 32'h0, resp);
        wr(A_ONE, 32'h6C, resp);
        settle();
        chk("pin1 input", 32'(pin1_io_oe_b), 32'h1);
        chk("pin2 follows high", 32'(output2_pin_out), 32'h1);
        @(posedge mclk);
        ext1 <= 1'b0;
        settle();
        chk("pin2 follows low", 32'(output2_pin_out), 32'h0);
        @(posedge mclk);
        ext1 <= 1'b1;
        wr(A_ONE, 32'h4C, resp);
        // Pin 3 as warm-reset input, then as plain output
        settle();
        chk("pin3 input", 32'(pin3_io_oe_b), 32'h1);
        @(posedge mclk);
        ext3 <= 1'b0;
        settle();
        chk("warm reset", 32'(buck_warm_reset), 32'h1);
        wr(A_TWO, 32'h40, resp);
        settle();
        chk("pin3 output low", 32'(pin3_io_oe_b), 32'h0);
        chk("warm reset off", 32'(buck_warm_reset), 32'h0);
        @(posedge mclk);
        ext3 <= 1'b1;
        wr(A_LVL, 32'h4, resp);
        settle();
        chk("pin3 output high", 32'(pin3_io_oe_b), 32'h1);
        wr(A_TWO, 32'hC0, resp);
        // Overvoltage only watched in tight mode
        // Clock enable low freezes the synchronisers and the bus
        @(posedge mclk);
        ov_raw_b <= 1'b0;
        ce <= 1'b0;
        settle();
        chk("ov frozen", 32'({overvoltage_flag, awready, arready}), 32'h0);
        @(posedge mclk);
        ce <= 1'b1;
        settle();
        chk("ov flagged", 32'(overvoltage_flag), 32'h1);
        rd(A_STS, d, resp);
        chk("status ov", 32'(d[1]), 32'h1);
        wr(A_ONE, 32'h48, resp);
        settle();
        chk("ov ignored", 32'(overvoltage_flag), 32'h0);
        chk("trim tight off", 32'(trim.supervisor_tight_mode), 32'h0);
        @(posedge mclk);
        ov_raw_b <= 1'b1;
        // Power-good delay for every code, undelayed fall
        for (int c = 0; c < 4; c++) begin
            wr(A_ONE, 32'h44 | (c << 3), resp);
            @(posedge mclk);
            pgood_raw <= 1'b1;
            wait_for(0, 1'b1, n);
            chk("pgood delay", 32'(n >= pg_cyc[c] - 1 && n <= pg_cyc[c] + 6), 32'h1);
            rd(A_STS, d, resp);
            chk("status pgood", 32'(d[0]), 32'h1);
            @(posedge mclk);
            pgood_raw <= 1'b0;
            wait_for(0, 1'b0, n);
            chk("pgood fall", 32'(n <= 4), 32'h1);
        end
        // Button hold, short then long
        for (int l = 0; l < 2; l++) begin
            wr(A_ONE, l ? 32'hCC : 32'h4C, resp);
            @(posedge mclk);
            button_b <= 1'b0;
            wait_for(1, 1'b1, n);
            chk("button hold", 32'(n >= (l ? PB_L : PB_S) - 1 && n <= (l ? PB_L : PB_S) + 6),
                32'h1);
            @(negedge mclk);
            chk("button pulse", 32'(pb_reset), 32'h0);
            @(posedge mclk);
            button_b <= 1'b1;
            settle();
        end
        results();
    end
endmodule : tb
`default_nettype wire
